// ===== core/acs_pkg.sv
// Constants and types shared by the converter scan control block
package acs_pkg;

  // --------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------
  localparam logic [7:0]  ACS_OFS_CONTROL = 8'h00;
  localparam logic [7:0]  ACS_OFS_RESULT  = 8'h04;
  localparam logic [7:0]  ACS_OFS_IRQ_EN  = 8'h0C;

  // --------------------------------------------------------------
  // Control register fields
  // --------------------------------------------------------------
  localparam int          ACS_SEL_LSB     = 0;
  localparam int          ACS_DIV_LSB     = 8;
  localparam int          ACS_BURST_BIT   = 16;
  localparam int          ACS_CONVERSION_LENGTH_LSB    = 17;
  localparam int          ACS_START_LSB   = 24;
  localparam int          ACS_EDGE_BIT    = 27;

  // --------------------------------------------------------------
  // Result and interrupt enable fields
  // --------------------------------------------------------------
  localparam int          ACS_RES_LSB     = 6;
  localparam int          ACS_CHN_LSB     = 24;
  localparam int          ACS_OVR_BIT     = 30;
  localparam int          ACS_DONE_BIT    = 31;
  localparam int          ACS_GIE_BIT     = 8;

  // --------------------------------------------------------------
  // Values and counts
  // --------------------------------------------------------------
  localparam logic [7:0]  ACS_SEL_RESET   = 8'h00;
  localparam logic [7:0]  ACS_SEL_EMPTY   = 8'h01;
  localparam logic [7:0]  ACS_DIV_RESET   = 8'h00;
  localparam logic [2:0]  ACS_CONVERSION_LENGTH_RESET  = 3'h0;
  localparam logic [2:0]  ACS_START_NONE  = 3'h0;
  localparam logic [2:0]  ACS_START_NOW   = 3'h1;
  localparam logic [8:0]  ACS_IRQ_RESET   = 9'h100;
  localparam logic [3:0]  ACS_FULL_CLOCKS = 4'hB;
  localparam logic [9:0]  ACS_RES_FULL    = 10'h3FF;

  typedef enum logic [0:0]
  {
    ACS_IDLE = 1'b0,
    ACS_RUN  = 1'b1
  } acs_phase_t;

endpackage : acs_pkg

// ===== core/acs_conv_timer.sv
// Converter clock divider and per-conversion clock counter
module acs_conv_timer
  import acs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [7:0] divider,
  input  wire logic       start,
  input  wire logic [3:0] length,
  output logic            conv_clk_tick,
  output logic            conv_finish
);

  typedef struct packed {
    logic [7:0] pre;
    logic [3:0] cnt;
    logic       run;
    logic       tick;
    logic       fin;
  } acs_timer_t;

  acs_timer_t st;
  acs_timer_t next_st;

  // --------------------------------------------------------------
  // Divide and count
  // --------------------------------------------------------------
  always_comb
  begin
    next_st      = st;
    next_st.tick = 1'b0;
    next_st.fin  = 1'b0;
    if (start)
    begin
      next_st.run = 1'b1;
      next_st.pre = 8'h00;
      next_st.cnt = length;
    end
    else if (st.run)
    begin
      if (st.pre == divider)
      begin
        next_st.pre  = 8'h00;
        next_st.tick = 1'b1;
        if (st.cnt == 4'h1)
        begin
          next_st.run = 1'b0;
          next_st.fin = 1'b1;
        end
        else
        begin
          next_st.cnt = st.cnt - 4'h1;
        end
      end
      else
      begin
        next_st.pre = st.pre + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign conv_clk_tick = st.tick;
  assign conv_finish   = st.fin;

endmodule : acs_conv_timer

// ===== core/acs_scan_ctrl.sv
// Channel scan control of the successive approximation converter
//
// Summary of operation
// - Control bits 7 to 0 form a mask where bit n picks analog input n.
// - In scan mode any mix of mask bits, up to all eight, is accepted.
// - An all zero mask acts as if only channel 0 were chosen.
// - The converter clock is the bus clock divided by bits 15:8 plus one.
// - With bit 16 clear a software conversion takes 11 converter clocks.
// - With bit 16 set conversions repeat back to back over the mask.
// - A scan starts at the lowest chosen channel and then goes upward.
// - Clearing bit 16 stops scanning but lets the running one finish.
// - In scan mode a non zero trigger code blocks all conversions.
// - Outside scan mode trigger code 1 starts now and code 0 never.
// - Done flag bit 31 sets at completion; a result read or control
//       write clears it.
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
module acs_scan_ctrl
  import acs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [9:0]  sar_data,
  output logic [2:0]       analog_inputs_select,
  output logic             conv_start,
  output logic             conv_clk_tick,
  output logic             conv_done,
  output logic             global_done_irq_enable
);

  typedef struct packed {
    logic        wait_q;
    logic [31:0] rdata;
    logic [7:0]  sel;
    logic [7:0]  div;
    logic        burst;
    logic [2:0]  conversion_length;
    logic [2:0]  start;
    logic        edge_fall;
    logic [8:0]  irq_en;
    logic        sw_req;
    acs_phase_t  phase;
    logic        scanning;
    logic        kick;
    logic        in_burst;
    logic [2:0]  cur;
    logic [2:0]  shift;
    logic [3:0]  len;
    logic [9:0]  sync1;
    logic [9:0]  sync2;
    logic [9:0]  result;
    logic [2:0]  res_chan;
    logic        overrun;
    logic        done;
  } acs_state_t;

  acs_state_t st;
  acs_state_t next_st;
  logic       finish;
  logic       tick;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // First chosen channel above 'from' when 'after' is set, else or past the top the lowest one
  function automatic logic [2:0] acs_pick
  (
    input logic [7:0] mask,
    input logic [2:0] from,
    input logic       after
  );
    logic [2:0] low;
    logic [2:0] up;
    logic       up_ok;
    low   = 3'h0;
    up    = 3'h0;
    up_ok = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      if (mask[i])
        low = i[2:0];
      if (mask[i] && after && (i[2:0] > from))
      begin
        up    = i[2:0];
        up_ok = 1'b1;
      end
    end
    acs_pick = up_ok ? up : low;
  endfunction : acs_pick

  function automatic logic [31:0] acs_ctrl_word(input acs_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ACS_SEL_LSB +: 8]   = s.sel;
    w[ACS_DIV_LSB +: 8]   = s.div;
    w[ACS_BURST_BIT]      = s.burst;
    w[ACS_CONVERSION_LENGTH_LSB +: 3]  = s.conversion_length;
    w[ACS_START_LSB +: 3] = s.start;
    w[ACS_EDGE_BIT]       = s.edge_fall;
    acs_ctrl_word = w;
  endfunction : acs_ctrl_word

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb
  begin
    logic [31:0] merged;
    logic [31:0] res_word;
    logic [7:0]  eff_sel;
    logic        take;
    logic        wr_ctrl;
    logic        rd_res;
    merged   = acs_ctrl_word(st);
    res_word = 32'h0000_0000;
    eff_sel  = 8'h00;
    take     = 1'b0;
    wr_ctrl  = 1'b0;
    rd_res   = 1'b0;
    next_st  = st;

    next_st.kick  = 1'b0;
    next_st.sync1 = sar_data;
    next_st.sync2 = st.sync1;

    // Bus slave: one wait cycle, commit when waitrequest is low
    take           = (avs_read || avs_write) && !st.wait_q;
    next_st.wait_q = !((avs_read || avs_write) && st.wait_q);
    wr_ctrl        = take && avs_write && (avs_address == ACS_OFS_CONTROL);
    rd_res         = take && avs_read && (avs_address == ACS_OFS_RESULT);

    res_word[ACS_RES_LSB +: 10] = st.result;
    res_word[ACS_CHN_LSB +: 3]  = st.res_chan;
    res_word[ACS_OVR_BIT]       = st.overrun;
    res_word[ACS_DONE_BIT]      = st.done;

    if (avs_address == ACS_OFS_CONTROL)
      next_st.rdata = acs_ctrl_word(st);
    else if (avs_address == ACS_OFS_RESULT)
      next_st.rdata = res_word;
    else if (avs_address == ACS_OFS_IRQ_EN)
      next_st.rdata = {23'h000000, st.irq_en};
    else
      next_st.rdata = 32'h0000_0000;

    for (int b = 0; b < 4; b++)
    begin
      if (avs_byteenable[b])
        merged[b*8 +: 8] = avs_writedata[b*8 +: 8];
    end

    // result read or control write clears done
    if (wr_ctrl || rd_res)
      next_st.done = 1'b0;

    if (wr_ctrl)
    begin
      next_st.sel       = merged[ACS_SEL_LSB +: 8];
      next_st.div       = merged[ACS_DIV_LSB +: 8];
      next_st.burst     = merged[ACS_BURST_BIT];
      next_st.conversion_length      = merged[ACS_CONVERSION_LENGTH_LSB +: 3];
      next_st.start     = merged[ACS_START_LSB +: 3];
      next_st.edge_fall = merged[ACS_EDGE_BIT];
      next_st.sw_req    = !merged[ACS_BURST_BIT] &&
                          (merged[ACS_START_LSB +: 3] == ACS_START_NOW);
    end
    if (take && avs_write && (avs_address == ACS_OFS_IRQ_EN))
      next_st.irq_en = avs_writedata[8:0];

    // Completion; setting done wins over a clear in the same cycle
    if (finish)
    begin
      next_st.phase    = ACS_IDLE;
      next_st.result   = st.sync2 & (ACS_RES_FULL << st.shift);
      next_st.res_chan = st.cur;
      next_st.done     = 1'b1;
      next_st.overrun  = st.in_burst && st.done && !rd_res;
    end

    eff_sel = (st.sel == 8'h00) ? ACS_SEL_EMPTY : st.sel;

    // a cleared scan bit only ends the sequence
    if (!st.burst)
      next_st.scanning = 1'b0;

    if ((st.phase == ACS_IDLE) || finish)
    begin
      if (st.burst && (st.start == ACS_START_NONE))
      begin
        next_st.kick     = 1'b1;
        next_st.phase    = ACS_RUN;
        next_st.in_burst = 1'b1;
        next_st.scanning = 1'b1;
        next_st.cur      = acs_pick(eff_sel, st.cur, st.scanning);
        // length code trims clocks and bits
        next_st.len      = ACS_FULL_CLOCKS - {1'b0, st.conversion_length};
        next_st.shift    = st.conversion_length;
      end
      else if (st.sw_req && !st.burst)
      begin
        next_st.kick     = 1'b1;
        next_st.phase    = ACS_RUN;
        next_st.in_burst = 1'b0;
        next_st.sw_req   = 1'b0;
        next_st.cur      = acs_pick(eff_sel, 3'h0, 1'b0);
        next_st.len      = ACS_FULL_CLOCKS;
        next_st.shift    = 3'h0;
      end
    end
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    // idle with cleared control fields after reset; irq_en loads 9'h100
    if (reset)
    begin
      st        <= '0;
      st.wait_q <= 1'b1;
      st.sel    <= ACS_SEL_RESET;
      st.div    <= ACS_DIV_RESET;
      st.conversion_length   <= ACS_CONVERSION_LENGTH_RESET;
      st.start  <= ACS_START_NONE;
      st.irq_en <= ACS_IRQ_RESET;
      st.phase  <= ACS_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------
  // Converter timing
  // --------------------------------------------------------------
  acs_conv_timer u_timer
  (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .divider       (st.div),
    .start         (st.kick),
    .length        (st.len),
    .conv_clk_tick (tick),
    .conv_finish   (finish)
  );

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign avs_readdata           = st.rdata;
  assign avs_waitrequest        = st.wait_q;
  assign analog_inputs_select   = st.cur;
  assign conv_start             = st.kick;
  assign conv_clk_tick          = tick;
  assign conv_done              = st.done;
  assign global_done_irq_enable = st.irq_en[ACS_GIE_BIT];

endmodule : acs_scan_ctrl

// ===== verif/acs_sar_model.sv
// Analog input model feeding the converter cell
module acs_sar_model
  import acs_pkg::*;
(
  input  wire logic [2:0] analog_inputs_select,
  output logic      [9:0] sar_data
);
  timeunit 1ns;
  timeprecision 1ns;

  // Each input holds its own level, so a wrong channel shows in the result
  assign sar_data = {analog_inputs_select, 7'h5A};
endmodule : acs_sar_model

// ===== verif/acs_scan_ctrl_assertions.sv
// Port checks for the converter scan control block
module acs_scan_ctrl_assertions
  import acs_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic [2:0]  analog_inputs_select,
  input wire logic        conv_start,
  input wire logic        conv_clk_tick,
  input wire logic        conv_done
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [31:0] sn;
  logic [3:0]  tcnt, elen;
  logic [8:0]  gap;
  logic [7:0]  ediv, m;
  logic [2:0]  prev, exp_ch;
  logic        first;

  // Wraps past channel 7 back to the lowest chosen one
  function automatic logic [2:0] pick(input logic [7:0] mk,
                                      input logic [2:0] s);
    pick = s;
    for (int i = 7; i >= 0; i--)
      if (mk[3'(s + 3'(i))]) pick = 3'(s + 3'(i));
  endfunction : pick

  assign m = (sn[7:0] == 8'h00) ? 8'h01 : sn[7:0];
  assign exp_ch = (sn[16] && !first) ? pick(m, prev + 3'h1) : pick(m, 3'h0);

  // Byte enables are taken as all set; the bench never writes partial words
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sn    <= 32'h0;
      tcnt  <= 4'h0;
      gap   <= 9'h0;
      first <= 1'b1;
    end
    else
    begin
      if (avs_write && !avs_waitrequest && avs_address == ACS_OFS_CONTROL)
        sn <= avs_writedata;
      tcnt  <= conv_start ? 4'h0 : tcnt + 4'(conv_clk_tick);
      gap   <= conv_clk_tick ? 9'h0 : gap + 9'h1;
      first <= !sn[16] || (first && !conv_start);
      if (conv_start)
      begin
        elen <= sn[16] ? 4'hB - {1'h0, sn[19:17]} : 4'hB;
        ediv <= sn[15:8];
        prev <= analog_inputs_select;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_reset_idle: assert property (disable iff (1'b0) reset |=>
    !conv_start && !conv_done && analog_inputs_select == 3'h0)
    else $error("outputs not idle after reset");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  a_conv_len: assert property ($rose(conv_done) |-> tcnt == elen)
    else $error("wrong clock count per conversion");
  a_tick_gap: assert property (conv_clk_tick && tcnt != 4'h0 |->
    gap == {1'h0, ediv})
    else $error("converter clock period wrong");
  a_chan_order: assert property (conv_start |->
    analog_inputs_select == exp_ch)
    else $error("wrong channel converted");
  a_scan_next: assert property ($rose(conv_done) && sn[16] &&
    sn[26:24] == 3'h0 |-> conv_start)
    else $error("scan not back to back");
  a_trig_block: assert property (sn[16] && sn[26:24] != 3'h0 &&
    $stable(sn) |-> !conv_start)
    else $error("scan started with trigger code set");
  a_done_clear: assert property (!avs_waitrequest &&
    ((avs_read && avs_address == ACS_OFS_RESULT) ||
     (avs_write && avs_address == ACS_OFS_CONTROL))
    |=> !conv_done || $rose(conv_done))
    else $error("done flag not cleared");
endmodule : acs_scan_ctrl_assertions

bind acs_scan_ctrl acs_scan_ctrl_assertions chk_i (.*);

// ===== verif/acs_scan_ctrl_test.sv
// Self-checking bench for the converter scan control block
module acs_scan_ctrl_test
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys = 1'b0, reset = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic        avs_waitrequest, conv_start, conv_clk_tick, conv_done, gie;
  logic [9:0]  sar_data;
  logic [2:0]  analog_inputs_select;
  int          bad_count = 0, n_compared = 0, n_starts = 0;

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (conv_start === 1'b1) n_starts++;

  acs_scan_ctrl dut (.clk_sys(clk_sys), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sar_data(sar_data),
    .analog_inputs_select(analog_inputs_select), .conv_start(conv_start),
    .conv_clk_tick(conv_clk_tick), .conv_done(conv_done),
    .global_done_irq_enable(gie));
  acs_sar_model pins (.analog_inputs_select(analog_inputs_select),
    .sar_data(sar_data));

  task give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Stops the run rather than hang when an answer never comes
  task wait_ev(input int kind);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while ((kind == 2 ? avs_waitrequest : kind ? conv_start : conv_done)
           !== (kind != 2) && n < 500);
    if (n >= 500)
    begin
      bad_count++;
      give_verdict();
    end
  endtask : wait_ev

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    wait_ev(2);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task t_reset;
    logic [31:0] q;
    chk("done", conv_done, 0);
    bus(0, ACS_OFS_CONTROL, 0, q);
    chk("ctrl", q, 0);
    bus(0, ACS_OFS_IRQ_EN, 0, q);
    chk("irq_en", q, 32'h100);
    chk("gie_reset", gie, 1);
    bus(0, 8'h08, 0, q);
    chk("unmapped", q, 0);
    $display("t_reset finished");
  endtask : t_reset

  task t_single;
    logic [31:0] q;
    logic [2:0]  ch;
    for (int i = 0; i < 2; i++)
    begin
      ch = i ? 3'h6 : 3'h0;
      bus(1, ACS_OFS_CONTROL, i ? 32'h0100_1640 : 32'h0100_1600, q);
      wait_ev(0);
      bus(0, ACS_OFS_RESULT, 0, q);
      chk("result", q, {1'h1, 4'h0, ch, 8'h00, ch, 7'h5A, 6'h00});
      bus(0, ACS_OFS_RESULT, 0, q);
      chk("done_bit", q[31], 0);
    end
    bus(0, ACS_OFS_CONTROL, 0, q);
    chk("ctrl_back", q[19:0], 32'h01640);
    // Every code other than start-now must leave the converter idle
    for (int c = 0; c < 8; c++)
      if (c != 1)
      begin
        bus(1, ACS_OFS_CONTROL, {5'h00, 3'(c), 24'h000001}, q);
        repeat (30) @(posedge clk_sys);
        chk("no_start", conv_done, 0);
      end
    $display("t_single finished");
  endtask : t_single

  task t_scan;
    logic [31:0] q;
    logic [14:0] ex;
    int          s;
    ex = 15'h55EA;
    bus(1, ACS_OFS_IRQ_EN, 0, q);
    @(posedge clk_sys);
    chk("gie_off", gie, 0);
    bus(1, ACS_OFS_CONTROL, 32'h000F_16A4, q);
    for (int k = 0; k < 5; k++)
    begin
      wait_ev(1);
      chk("scan_ch", analog_inputs_select, ex[3*k +: 3]);
    end
    bus(1, ACS_OFS_CONTROL, 32'h0000_16A4, q);
    s = n_starts;
    wait_ev(0);
    // channel 5 kept to three result bits
    bus(0, ACS_OFS_RESULT, 0, q);
    chk("scan_res", q, {1'h1, 4'h0, 3'h5, 8'h00, 3'h5, 7'h00, 6'h00});
    repeat (40) @(posedge clk_sys);
    chk("stopped", 32'(n_starts), 32'(s));
    $display("t_scan finished");
  endtask : t_scan

  task t_trig;
    logic [31:0] q;
    int          s;
    s = n_starts;
    bus(1, ACS_OFS_CONTROL, 32'h0201_0001, q);
    repeat (40) @(posedge clk_sys);
    chk("blocked", 32'(n_starts), 32'(s));
    bus(1, ACS_OFS_CONTROL, 0, q);
    $display("t_trig finished");
  endtask : t_trig

  initial
  begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_single();
    t_scan();
    t_trig();
    give_verdict();
  end
endmodule : acs_scan_ctrl_test
